// file: test/mlf_top_asserts.sv
// Checker for the motor lock fault block, watching only the top module's ports.
// Assumes one core clock with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mlf_top_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Flags
  input wire logic position_detect_timeout_det,
  input wire logic position_detect_freq_det,
  input wire logic current_loop_sat,
  input wire logic speed_loop_sat,
  input wire logic position_detect_timeout_fault,
  input wire logic position_detect_freq_fault,
  input wire logic current_loop_sat_flag,
  input wire logic speed_loop_sat_flag,
  // Fault and gate driver
  input wire logic fault_n,
  input wire logic [2:0] gate_drive_state,
  input wire logic [2:0] hs_gate_on,
  input wire logic [2:0] ls_gate_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_hs_brake_gates: assert property (gate_drive_state == mlf_pkg::DRV_HS_BRAKE |-> hs_gate_on == 3'h7)
    else $error("high brake without all high gates on");
  a_ls_brake_gates: assert property (gate_drive_state == mlf_pkg::DRV_LS_BRAKE |-> ls_gate_on == 3'h7)
    else $error("low brake without all low gates on");
  a_drive_needs_fault: assert property (gate_drive_state != mlf_pkg::DRV_NORMAL |-> !fault_n)
    else $error("gate driver acting while fault pin idle");
  a_pd_timeout_cause: assert property (position_detect_timeout_fault |-> $past(position_detect_timeout_det))
    else $error("timeout fault without detector");
  a_pd_freq_cause: assert property (!position_detect_freq_det |=> !position_detect_freq_fault)
    else $error("frequency fault without detector");
  a_sat_flag_cause: assert property ((current_loop_sat_flag |-> $past(current_loop_sat))
    and (speed_loop_sat_flag |-> $past(speed_loop_sat))) else $error("saturation flag without cause");
  a_pready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered in time");
  a_pready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_prdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data driven outside a transfer");
endmodule
bind mlf_top mlf_top_asserts chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .position_detect_timeout_det(position_detect_timeout_det),
  .position_detect_freq_det(position_detect_freq_det), .current_loop_sat(current_loop_sat),
  .speed_loop_sat(speed_loop_sat), .position_detect_timeout_fault(position_detect_timeout_fault),
  .position_detect_freq_fault(position_detect_freq_fault), .current_loop_sat_flag(current_loop_sat_flag),
  .speed_loop_sat_flag(speed_loop_sat_flag), .fault_n(fault_n), .gate_drive_state(gate_drive_state),
  .hs_gate_on(hs_gate_on), .ls_gate_on(ls_gate_on));
`default_nettype wire

// file: test/mlf_top_tb.sv
// Self-checking bench for the motor lock fault block, driven over APB and its flag inputs.
// Assumes shortened retry counts so every wait stays within a few hundred cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module mlf_top_tb;
  localparam logic [31:0] SHORT = 32'h0000000a;
  localparam logic [31:0] HALF = 32'h00000014;
  localparam logic [31:0] STEP = 32'h00000028;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic lock_det = 1'b0;
  logic [2:0] kind_det = 3'h0;
  logic [1:0] pd_det = 2'h0, sat_in = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, overspeed_lock_enable, fault_n, irq;
  logic position_detect_timeout_fault, position_detect_freq_fault, current_loop_sat_flag, speed_loop_sat_flag;
  logic [2:0] overspeed_threshold, backemf_deviation_threshold, absent_motor_current_threshold;
  logic [2:0] gate_drive_state, hs_gate_on, ls_gate_on;
  int num_errors = 0;
  int tests_run = 0;
  logic [3:0] lat_codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hc};
  logic [3:0] wait_codes [4] = '{4'h0, 4'h1, 4'h2, 4'hf};

  always #2.5 clk = ~clk;

  mlf_top #(.P_RETRY_SHORT_CYC(SHORT), .P_RETRY_HALF_CYC(HALF), .P_RETRY_STEP_CYC(STEP)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_lock_det(lock_det),
    .overspeed_det(kind_det[2]), .backemf_det(kind_det[1]), .absent_motor_det(kind_det[0]),
    .position_detect_timeout_det(pd_det[1]), .position_detect_freq_det(pd_det[0]),
    .current_loop_sat(sat_in[1]), .speed_loop_sat(sat_in[0]), .overspeed_lock_enable(overspeed_lock_enable),
    .overspeed_threshold(overspeed_threshold), .backemf_deviation_threshold(backemf_deviation_threshold),
    .absent_motor_current_threshold(absent_motor_current_threshold),
    .position_detect_timeout_fault(position_detect_timeout_fault),
    .position_detect_freq_fault(position_detect_freq_fault), .current_loop_sat_flag(current_loop_sat_flag),
    .speed_loop_sat_flag(speed_loop_sat_flag), .fault_n(fault_n), .irq(irq),
    .gate_drive_state(gate_drive_state), .hs_gate_on(hs_gate_on), .ls_gate_on(ls_gate_on));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Entered just after a rising edge; one idle cycle follows so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse_lock();
    lock_det <= 1'b1;
    @(posedge clk);
    lock_det <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [2:0] exp_drive(input logic [3:0] c);
    return (c == mlf_pkg::ACT_REPORT) ? mlf_pkg::DRV_NORMAL : 3'(c[1:0]) + 3'h1;
  endfunction

  function automatic int exp_wait(input logic [3:0] c);
    return (c == 4'h0) ? int'(SHORT) : (c == 4'h1) ? int'(HALF) : (int'(c) - 1) * int'(STEP);
  endfunction

  initial begin
    logic [31:0] v, d;
    logic e;
    logic [3:0] c;
    int n, w;
    void'($urandom(89080));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, mlf_pkg::ADDR_SETTINGS_SECOND, 32'h0, v, e);
    `CHK("second_reset", mlf_pkg::SETTINGS_SECOND_RST, v)
    apb(1'b0, 12'h000, 32'h0, v, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("fault_idle", 1'b1, fault_n)
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom();
      wr(mlf_pkg::ADDR_SETTINGS_SECOND, d);
      apb(1'b0, mlf_pkg::ADDR_SETTINGS_SECOND, 32'h0, v, e);
      `CHK("second_rw", d, v)
      `CHK("overspeed_en", d[30], overspeed_lock_enable)
      `CHK("overspeed_thr", d[27:25], overspeed_threshold)
      `CHK("backemf_thr", d[24:22], backemf_deviation_threshold)
      `CHK("absent_thr", d[21:19], absent_motor_current_threshold)
    end
    $display("test register done");
    pd_det <= 2'h3;
    sat_in <= 2'h3;
    for (int en = 0; en < 2; en++) begin
      wr(mlf_pkg::ADDR_SETTINGS_FIRST, en ? 32'h7 : 32'h0);
      cyc(2);
      `CHK("pd_timeout", 1'(en), position_detect_timeout_fault)
      `CHK("pd_freq", 1'(en), position_detect_freq_fault)
      `CHK("cur_sat", 1'(en), current_loop_sat_flag)
      `CHK("spd_sat", 1'(en), speed_loop_sat_flag)
    end
    pd_det <= 2'h0;
    sat_in <= 2'h0;
    $display("test enables done");
    wr(mlf_pkg::ADDR_SETTINGS_SECOND, 32'h0);
    foreach (lat_codes[i]) begin
      c = lat_codes[i];
      wr(mlf_pkg::ADDR_SETTINGS_FIRST, {25'h0, c, 3'h0});
      pulse_lock();
      cyc(3);
      `CHK("lock_fault_n", c > 4'h8, fault_n)
      `CHK("lock_drive", (c > 4'h8) ? 3'h0 : exp_drive(c), gate_drive_state)
      `CHK("hs_gates", (c == 4'h2) ? 3'h7 : 3'h0, hs_gate_on)
      `CHK("ls_gates", (c == 4'h3) ? 3'h7 : 3'h0, ls_gate_on)
      wr(mlf_pkg::ADDR_CONTROL, 32'h1);
      cyc(2);
      `CHK("cleared", 1'b1, fault_n)
    end
    $display("test latched done");
    wr(mlf_pkg::ADDR_SETTINGS_FIRST, 32'h0);
    for (int k = 0; k < 3; k++) begin
      for (int en = 0; en < 2; en++) begin
        wr(mlf_pkg::ADDR_SETTINGS_SECOND, en ? (32'h10000000 << k) : 32'h0);
        kind_det[k] <= 1'b1;
        cyc(1);
        kind_det[k] <= 1'b0;
        cyc(3);
        `CHK("kind_lock", en == 0, fault_n)
        wr(mlf_pkg::ADDR_CONTROL, 32'h1);
      end
    end
    $display("test lock kinds done");
    for (int a = 4; a < 8; a++) begin
      wr(mlf_pkg::ADDR_SETTINGS_SECOND, 32'h1);
      wr(mlf_pkg::ADDR_SETTINGS_FIRST, {21'h0, wait_codes[a-4], 4'(a), 3'h0});
      pulse_lock();
      cyc(2);
      `CHK("retry_drive", exp_drive(4'(a)), gate_drive_state)
      `CHK("retry_fault", 1'b0, fault_n)
      n = 0;
      while (fault_n !== 1'b1 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 2000) begin
        num_errors++;
        conclude();
      end
      w = exp_wait(wait_codes[a-4]);
      `CHK("retry_len", 1'b1, n >= w - 4 && n <= w + 4)
      pulse_lock();
      cyc(w + 8);
      `CHK("retry_latched", 1'b0, fault_n)
      `CHK("latched_drive", exp_drive(4'(a)), gate_drive_state)
      wr(mlf_pkg::ADDR_CONTROL, 32'h1);
      cyc(2);
    end
    $display("test retry done");
    wr(mlf_pkg::ADDR_SETTINGS_FIRST, {25'h0, mlf_pkg::ACT_REPORT, 3'h0});
    wr(mlf_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, mlf_pkg::ADDR_IRQ_STATUS, 32'h0, v, e);
    pulse_lock();
    cyc(2);
    `CHK("irq_masked", 1'b0, irq)
    wr(mlf_pkg::ADDR_IRQ_MASK, 32'h1);
    cyc(2);
    `CHK("irq_on", 1'b1, irq)
    apb(1'b0, mlf_pkg::ADDR_IRQ_STATUS, 32'h0, v, e);
    `CHK("status_lock", 1'b1, v[mlf_pkg::IRQ_LOCK_DET])
    cyc(2);
    `CHK("irq_off", 1'b0, irq)
    wr(mlf_pkg::ADDR_CONTROL, 32'h1);
    $display("test interrupt done");
    conclude();
  end
endmodule
`default_nettype wire

// file: verilog/mlf_pkg.sv
// Package of constants for the motor lock fault block: register map, field layout,
// encodings and retry timing.
// Assumes a 200 MHz core clock and APB with 32-bit data and word-aligned registers.
package mlf_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_SETTINGS_FIRST = 10'h090;
  localparam logic [9:0] IDX_SETTINGS_SECOND = 10'h092;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0a0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0a1;
  localparam logic [9:0] IDX_LOCK_STATE = 10'h0a2;
  localparam logic [9:0] IDX_CONTROL = 10'h0a3;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_SETTINGS_FIRST = {IDX_SETTINGS_FIRST, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SETTINGS_SECOND = {IDX_SETTINGS_SECOND, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_LOCK_STATE = {IDX_LOCK_STATE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};

  // Reset values
  localparam logic [31:0] SETTINGS_FIRST_RST = 32'h00000000;
  localparam logic [31:0] SETTINGS_SECOND_RST = 32'h00000000;
  localparam logic [6:0] IRQ_MASK_RST = 7'h00;

  // First settings register fields
  localparam int F1_WIDTH = 11;
  localparam int RETRY_WAIT_LSB = 7;
  localparam int RETRY_WAIT_MSB = 10;
  localparam int ACTION_LSB = 3;
  localparam int ACTION_MSB = 6;
  localparam int PD_TIMEOUT_EN_BIT = 2;
  localparam int PD_FREQ_EN_BIT = 1;
  localparam int SAT_EN_BIT = 0;

  // Second settings register fields
  localparam int OVERSPEED_EN_BIT = 30;
  localparam int BACKEMF_EN_BIT = 29;
  localparam int ABSENT_EN_BIT = 28;
  localparam int OVERSPEED_THR_LSB = 25;
  localparam int OVERSPEED_THR_MSB = 27;
  localparam int BACKEMF_THR_LSB = 22;
  localparam int BACKEMF_THR_MSB = 24;
  localparam int ABSENT_THR_LSB = 19;
  localparam int ABSENT_THR_MSB = 21;
  localparam int RETRY_LIMIT_LSB = 0;
  localparam int RETRY_LIMIT_MSB = 2;

  // Interrupt status bits
  localparam int IRQ_W = 7;
  localparam int IRQ_LOCK_DET = 0;
  localparam int IRQ_LOCK_LATCH = 1;
  localparam int IRQ_RETRY_DONE = 2;
  localparam int IRQ_PD_TIMEOUT = 3;
  localparam int IRQ_PD_FREQ = 4;
  localparam int IRQ_CUR_SAT = 5;
  localparam int IRQ_SPD_SAT = 6;

  // Lock state register fields and control bit
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_RETRY_BIT = 2;
  localparam int ST_DRIVE_LSB = 4;
  localparam int ST_CNT_LSB = 8;
  localparam int CTRL_CLEAR_BIT = 0;

  // Lock action codes
  localparam logic [3:0] ACT_LATCH_TRI = 4'h0;
  localparam logic [3:0] ACT_LATCH_RECIRC = 4'h1;
  localparam logic [3:0] ACT_LATCH_HS = 4'h2;
  localparam logic [3:0] ACT_LATCH_LS = 4'h3;
  localparam logic [3:0] ACT_RETRY_TRI = 4'h4;
  localparam logic [3:0] ACT_RETRY_RECIRC = 4'h5;
  localparam logic [3:0] ACT_RETRY_HS = 4'h6;
  localparam logic [3:0] ACT_RETRY_LS = 4'h7;
  localparam logic [3:0] ACT_REPORT = 4'h8;

  // Gate drive state codes
  localparam logic [2:0] DRV_NORMAL = 3'h0;
  localparam logic [2:0] DRV_TRISTATE = 3'h1;
  localparam logic [2:0] DRV_RECIRC = 3'h2;
  localparam logic [2:0] DRV_HS_BRAKE = 3'h3;
  localparam logic [2:0] DRV_LS_BRAKE = 3'h4;

  // Retry wait timing
  localparam int CLK_HZ = 200_000_000;
  localparam int RETRY_SHORT_MS = 100;
  localparam int RETRY_HALF_MS = 500;
  localparam int RETRY_STEP_MS = 1000;
  localparam int RETRY_SHORT_CYC = RETRY_SHORT_MS * (CLK_HZ / 1000);
  localparam int RETRY_HALF_CYC = RETRY_HALF_MS * (CLK_HZ / 1000);
  localparam int RETRY_STEP_CYC = RETRY_STEP_MS * (CLK_HZ / 1000);
  localparam logic [3:0] RETRY_CODE_SHORT = 4'h0;
  localparam logic [3:0] RETRY_CODE_HALF = 4'h1;
  localparam int TMR_W = 32;

endpackage

// file: verilog/mlf_retry_timer.sv
// Retry wait timer: turns the retry wait code into a cycle count and counts it out.
// Assumes start is a one-cycle pulse on the core clock; a new start restarts the wait.
`timescale 1ns/1ps
`default_nettype none
module mlf_retry_timer #(
  parameter logic [31:0] SHORT_CYC = 32'(mlf_pkg::RETRY_SHORT_CYC),
  parameter logic [31:0] HALF_CYC = 32'(mlf_pkg::RETRY_HALF_CYC),
  parameter logic [31:0] STEP_CYC = 32'(mlf_pkg::RETRY_STEP_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] code,
  // Status
  output logic busy,
  output logic done
);

  logic [mlf_pkg::TMR_W-1:0] cnt_r;
  logic [mlf_pkg::TMR_W-1:0] load_nxt;
  logic [63:0] prod;

  // 14 s at 200 MHz passes two to the thirty-first, so the product is taken wide
  always_comb begin
    prod = 64'(code - 4'h1) * 64'(STEP_CYC);
    if (code == mlf_pkg::RETRY_CODE_SHORT) begin
      load_nxt = SHORT_CYC;
    end else if (code == mlf_pkg::RETRY_CODE_HALF) begin
      load_nxt = HALF_CYC;
    end else begin
      load_nxt = prod[mlf_pkg::TMR_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || abort) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_r <= load_nxt - 32'h1;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      cnt_r <= cnt_r - 32'h1;
      done <= (cnt_r == 32'h0);
      busy <= (cnt_r != 32'h0);
    end else begin
      done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verilog/mlf_top.sv
// Motor lock fault configuration and action block with its APB register file.
// Assumes detector and loop flags come from logic on the same core clock.
// Operation
// - Retry wait code in bits 10-7 picks 100 ms, 500 ms, then 1 s to 14 s.
// - Action 0h: lock latches fault, fault pin low, gate driver tristated.
// - Actions 1h-3h: latched fault, fault pin low, recirculate, high or low brake.
// - Actions 4h,5h,7h: auto clear after wait; latch once retries reach limit.
// - Action 6h: auto clear after wait up to limit, high-side brake, fault low.
// - High brake turns on all three high FETs; low brake all three low.
// - Action 8h: report lock and assert fault pin only, no driver action.
// - Actions 9h, Ah, Ch disable motor lock detection entirely.
// - Position detect timeout fault reported only when bit 2 set.
// - Position detect frequency fault reported only when bit 1 set.
// - Current and speed loop saturation shown only when bit 0 set.
// - Second settings register, 32-bit read-write at index 92h, resets to zero.
// - Overspeed lock detection enabled only by bit 30.
// - Back-EMF lock detection enabled only by bit 29.
// - Absent motor lock detection enabled only by bit 28.
// - Overspeed threshold bits 27-25: 130% to 200% in 10% steps.
// - Back-EMF threshold bits 24-22: 10% to 80% in 10% steps.
// - Absent motor current threshold bits 21-19: codes 0h-7h.
`timescale 1ns/1ps
`default_nettype none
module mlf_top #(
  parameter logic [31:0] P_RETRY_SHORT_CYC = 32'(mlf_pkg::RETRY_SHORT_CYC),
  parameter logic [31:0] P_RETRY_HALF_CYC = 32'(mlf_pkg::RETRY_HALF_CYC),
  parameter logic [31:0] P_RETRY_STEP_CYC = 32'(mlf_pkg::RETRY_STEP_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mlf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Detector and loop flags
  input wire logic motor_lock_det,
  input wire logic overspeed_det,
  input wire logic backemf_det,
  input wire logic absent_motor_det,
  input wire logic position_detect_timeout_det,
  input wire logic position_detect_freq_det,
  input wire logic current_loop_sat,
  input wire logic speed_loop_sat,
  // Thresholds to the detectors
  output logic overspeed_lock_enable,
  output logic [2:0] overspeed_threshold,
  output logic [2:0] backemf_deviation_threshold,
  output logic [2:0] absent_motor_current_threshold,
  // Fault reporting
  output logic position_detect_timeout_fault,
  output logic position_detect_freq_fault,
  output logic current_loop_sat_flag,
  output logic speed_loop_sat_flag,
  output logic fault_n,
  output logic irq,
  // Gate driver
  output logic [2:0] gate_drive_state,
  output logic [2:0] hs_gate_on,
  output logic [2:0] ls_gate_on
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LATCHED,
    ST_RETRY,
    ST_REPORT
  } mlf_state_e;

  mlf_state_e state_r;
  mlf_state_e state_nxt;
  logic [mlf_pkg::F1_WIDTH-1:0] settings_first_r;
  logic [31:0] settings_second_r;
  logic [mlf_pkg::IRQ_W-1:0] irq_status_r;
  logic [mlf_pkg::IRQ_W-1:0] irq_mask_r;
  logic [mlf_pkg::IRQ_W-1:0] irq_set;
  logic [2:0] retry_cnt_r;
  logic [2:0] drive_r;
  logic [2:0] drive_nxt;
  logic [3:0] action;
  logic [3:0] retry_code;
  logic [2:0] retry_limit;
  logic lock_hit;
  logic lock_disabled;
  logic retry_start;
  logic retry_done;
  logic sw_clear;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rd_data;

  assign action = settings_first_r[mlf_pkg::ACTION_MSB:mlf_pkg::ACTION_LSB];
  assign retry_code = settings_first_r[mlf_pkg::RETRY_WAIT_MSB:mlf_pkg::RETRY_WAIT_LSB];
  assign retry_limit = settings_second_r[mlf_pkg::RETRY_LIMIT_MSB:mlf_pkg::RETRY_LIMIT_LSB];

  // APB: one wait state; pready and prdata both come from flops
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign sw_clear = wr && (paddr == mlf_pkg::ADDR_CONTROL) && pwdata[mlf_pkg::CTRL_CLEAR_BIT];

  always_comb begin
    mapped = 1'b1;
    rd_data = 32'h00000000;
    case (paddr)
      mlf_pkg::ADDR_SETTINGS_FIRST: begin
        rd_data = 32'(settings_first_r);
      end
      mlf_pkg::ADDR_SETTINGS_SECOND: begin
        rd_data = settings_second_r;
      end
      mlf_pkg::ADDR_IRQ_STATUS: begin
        rd_data = 32'(irq_status_r);
      end
      mlf_pkg::ADDR_IRQ_MASK: begin
        rd_data = 32'(irq_mask_r);
      end
      mlf_pkg::ADDR_LOCK_STATE: begin
        rd_data[mlf_pkg::ST_FAULT_BIT] = (state_r != ST_IDLE);
        rd_data[mlf_pkg::ST_LATCH_BIT] = (state_r == ST_LATCHED);
        rd_data[mlf_pkg::ST_RETRY_BIT] = (state_r == ST_RETRY);
        rd_data[mlf_pkg::ST_DRIVE_LSB +: 3] = drive_r;
        rd_data[mlf_pkg::ST_CNT_LSB +: 3] = retry_cnt_r;
      end
      mlf_pkg::ADDR_CONTROL: begin
        rd_data = 32'h00000000;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h00000000 : rd_data;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Settings registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settings_first_r <= mlf_pkg::SETTINGS_FIRST_RST[mlf_pkg::F1_WIDTH-1:0];
      settings_second_r <= mlf_pkg::SETTINGS_SECOND_RST;
      irq_mask_r <= mlf_pkg::IRQ_MASK_RST;
    end else if (wr) begin
      if (paddr == mlf_pkg::ADDR_SETTINGS_FIRST) begin
        settings_first_r <= pwdata[mlf_pkg::F1_WIDTH-1:0];
      end
      if (paddr == mlf_pkg::ADDR_SETTINGS_SECOND) begin
        settings_second_r <= pwdata;
      end
      if (paddr == mlf_pkg::ADDR_IRQ_MASK) begin
        irq_mask_r <= pwdata[mlf_pkg::IRQ_W-1:0];
      end
    end
  end

  // Lock sources: motor lock ungated, the other three each gated by its own enable
  always_comb begin
    lock_disabled = (action > mlf_pkg::ACT_REPORT);
    lock_hit = !lock_disabled && (motor_lock_det
      || (overspeed_det && settings_second_r[mlf_pkg::OVERSPEED_EN_BIT])
      || (backemf_det && settings_second_r[mlf_pkg::BACKEMF_EN_BIT])
      || (absent_motor_det && settings_second_r[mlf_pkg::ABSENT_EN_BIT]));
  end

  // Driver state that an action code asks for
  function automatic logic [2:0] mlf_action_drive(input logic [3:0] code);
    case (code)
      mlf_pkg::ACT_LATCH_TRI, mlf_pkg::ACT_RETRY_TRI: begin
        mlf_action_drive = mlf_pkg::DRV_TRISTATE;
      end
      mlf_pkg::ACT_LATCH_RECIRC, mlf_pkg::ACT_RETRY_RECIRC: begin
        mlf_action_drive = mlf_pkg::DRV_RECIRC;
      end
      mlf_pkg::ACT_LATCH_HS, mlf_pkg::ACT_RETRY_HS: begin
        mlf_action_drive = mlf_pkg::DRV_HS_BRAKE;
      end
      mlf_pkg::ACT_LATCH_LS, mlf_pkg::ACT_RETRY_LS: begin
        mlf_action_drive = mlf_pkg::DRV_LS_BRAKE;
      end
      default: begin
        mlf_action_drive = mlf_pkg::DRV_NORMAL;
      end
    endcase
  endfunction

  // Lock state machine
  always_comb begin
    state_nxt = state_r;
    drive_nxt = drive_r;
    retry_start = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (lock_hit) begin
          drive_nxt = mlf_action_drive(action);
          if (action <= mlf_pkg::ACT_LATCH_LS) begin
            state_nxt = ST_LATCHED;
          end else if (action <= mlf_pkg::ACT_RETRY_LS) begin
            if (retry_cnt_r >= retry_limit) begin
              state_nxt = ST_LATCHED;
            end else begin
              state_nxt = ST_RETRY;
              retry_start = 1'b1;
            end
          end else begin
            state_nxt = ST_REPORT;
          end
        end
      end
      ST_RETRY: begin
        if (retry_done) begin
          state_nxt = ST_IDLE;
          drive_nxt = mlf_pkg::DRV_NORMAL;
        end
      end
      ST_LATCHED, ST_REPORT: begin
        state_nxt = state_r;
      end
      default: begin
        state_nxt = ST_IDLE;
        drive_nxt = mlf_pkg::DRV_NORMAL;
      end
    endcase
    // Software clear overrides any wait or latch
    if (sw_clear) begin
      state_nxt = ST_IDLE;
      drive_nxt = mlf_pkg::DRV_NORMAL;
      retry_start = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      drive_r <= mlf_pkg::DRV_NORMAL;
    end else begin
      state_r <= state_nxt;
      drive_r <= drive_nxt;
    end
  end

  // Consecutive retries are only forgotten on software clear or reset
  always_ff @(posedge clk) begin
    if (!rst_n || sw_clear) begin
      retry_cnt_r <= 3'h0;
    end else if (retry_start) begin
      retry_cnt_r <= retry_cnt_r + 3'h1;
    end
  end

  mlf_retry_timer #(
    .SHORT_CYC(P_RETRY_SHORT_CYC),
    .HALF_CYC(P_RETRY_HALF_CYC),
    .STEP_CYC(P_RETRY_STEP_CYC)
  ) u_retry_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(retry_start),
    .abort(sw_clear),
    .code(retry_code),
    .busy(),
    .done(retry_done)
  );

  // Gate driver and fault pin outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_drive_state <= mlf_pkg::DRV_NORMAL;
      hs_gate_on <= 3'h0;
      ls_gate_on <= 3'h0;
      fault_n <= 1'b1;
    end else begin
      gate_drive_state <= drive_nxt;
      hs_gate_on <= {3{drive_nxt == mlf_pkg::DRV_HS_BRAKE}};
      ls_gate_on <= {3{drive_nxt == mlf_pkg::DRV_LS_BRAKE}};
      fault_n <= (state_nxt == ST_IDLE);
    end
  end

  // Threshold and fault report outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overspeed_lock_enable <= 1'b0;
      overspeed_threshold <= 3'h0;
      backemf_deviation_threshold <= 3'h0;
      absent_motor_current_threshold <= 3'h0;
      position_detect_timeout_fault <= 1'b0;
      position_detect_freq_fault <= 1'b0;
      current_loop_sat_flag <= 1'b0;
      speed_loop_sat_flag <= 1'b0;
    end else begin
      overspeed_lock_enable <= settings_second_r[mlf_pkg::OVERSPEED_EN_BIT];
      overspeed_threshold <= settings_second_r[mlf_pkg::OVERSPEED_THR_MSB:mlf_pkg::OVERSPEED_THR_LSB];
      backemf_deviation_threshold <= settings_second_r[mlf_pkg::BACKEMF_THR_MSB:mlf_pkg::BACKEMF_THR_LSB];
      absent_motor_current_threshold <= settings_second_r[mlf_pkg::ABSENT_THR_MSB:mlf_pkg::ABSENT_THR_LSB];
      position_detect_timeout_fault <= irq_set[mlf_pkg::IRQ_PD_TIMEOUT];
      position_detect_freq_fault <= irq_set[mlf_pkg::IRQ_PD_FREQ];
      current_loop_sat_flag <= irq_set[mlf_pkg::IRQ_CUR_SAT];
      speed_loop_sat_flag <= irq_set[mlf_pkg::IRQ_SPD_SAT];
    end
  end

  // Interrupt events
  always_comb begin
    irq_set = '0;
    irq_set[mlf_pkg::IRQ_LOCK_DET] = lock_hit && (state_r == ST_IDLE);
    irq_set[mlf_pkg::IRQ_LOCK_LATCH] = (state_nxt == ST_LATCHED) && (state_r != ST_LATCHED);
    irq_set[mlf_pkg::IRQ_RETRY_DONE] = retry_done && (state_r == ST_RETRY) && !sw_clear;
    irq_set[mlf_pkg::IRQ_PD_TIMEOUT] = position_detect_timeout_det
      && settings_first_r[mlf_pkg::PD_TIMEOUT_EN_BIT];
    irq_set[mlf_pkg::IRQ_PD_FREQ] = position_detect_freq_det && settings_first_r[mlf_pkg::PD_FREQ_EN_BIT];
    irq_set[mlf_pkg::IRQ_CUR_SAT] = current_loop_sat && settings_first_r[mlf_pkg::SAT_EN_BIT];
    irq_set[mlf_pkg::IRQ_SPD_SAT] = speed_loop_sat && settings_first_r[mlf_pkg::SAT_EN_BIT];
  end

  // A read clears only the bits it returned; events after the capture edge survive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status_r <= '0;
    end else if (rd && (paddr == mlf_pkg::ADDR_IRQ_STATUS)) begin
      irq_status_r <= (irq_status_r & ~prdata[mlf_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_r <= irq_status_r | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

endmodule
`default_nettype wire
